/* hw/sar_adc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the
// converter control block. Assumes a 32-bit APB slave, byte addresses.
`ifndef SAR_ADC_CFG_SVH
`define SAR_ADC_CFG_SVH

// Register byte offsets, one aligned word each
`define CHAN_SEL_OFF    8'h00
`define CTRL_A_OFF      8'h04
`define CTRL_B_OFF      8'h08
`define RES_LOW_OFF     8'h0c
`define RES_HIGH_OFF    8'h10

// channel_select_register fields
`define REF_SEL_MSB     7
`define REF_SEL_LSB     6
`define CHAN_SEL_MSB    5
`define CHAN_SEL_LSB    0

// converter_control_a fields
`define ENABLE_BIT      7
`define START_BIT       6
`define AUTO_TRIG_BIT   5
`define DONE_FLAG_BIT   4
`define PRESC_MSB       2
`define PRESC_LSB       0

// converter_control_b fields
`define LEFT_ADJ_BIT    4
`define TRIG_SEL_MSB    2
`define TRIG_SEL_LSB    0

// Reset values
`define CHAN_SEL_RST    8'h00
`define CTRL_A_RST      8'h00
`define CTRL_B_RST      8'h00

// Special codes
`define TEMP_SENSOR_CODE 6'h22
`define FREE_RUN_SOURCE  3'h0
`define SAR_MSB_CODE     10'h200

// Conversion timing in ADC clock cycles
`define NORMAL_LEN      5'd13
`define NORMAL_SAMPLE   5'd1
`define FIRST_LEN       5'd25
`define FIRST_SAMPLE    5'd14
`define AUTO_LEN        5'd14
`define AUTO_SAMPLE     5'd2
`define SAR_BITS        5'd10

// System clock cycles of trigger synchronisation
`define TRIG_SYNC_CYCLES 3

`endif

/* hw/sar_adc_pkg.sv */
// Types shared by the converter control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sar_adc_pkg;

  typedef enum logic {IDLE, CONVERTING} conv_state_type;

  typedef enum logic [1:0] {NORMAL, FIRST, AUTO} conv_kind_type;

endpackage

/* hw/sar_adc_conversion_control.sv */
// Digital control of a 10-bit successive-approximation converter.
// Assumes an APB master, trigger flags synchronous to pclk and an analog
// array whose comparator answers within one ADC clock of a trial code.
// How it works
// - Ten-bit code by successive approximation trials.
// - Two-bit field picks the reference source.
// - Six-bit field picks channel and gain.
// - Gain bit chooses 1x/20x; single-ended bypasses.
// - Pins 0, 3, 7 shorted for offset.
// - Code 100010 selects the temperature sensor.
// - Selections apply only while converter enabled.
// - Result right adjusted unless left adjust.
// - Low byte read locks results until high.
// - Done flag set even when result discarded.
// - Start bit launches; reads one while converting.
// - Channel change waits for current conversion.
// - Trigger edge resets prescaler, starts when idle.
// - Source flag must clear before next trigger.
// - Done flag as source runs free.
// - Start bit works with auto trigger on.
// - Prescaler runs only while enabled.
// - Start waits for next ADC clock edge.
// - 13 cycles normal, 25 for first.
// - Completion stores result, sets flag, ends start unless free running.
// - Auto conversion samples at 2, lasts longer.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"

module sar_adc_conversion_control (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger sources and interrupt vector acknowledge
  input  wire logic [7:0]  trigger_flags,
  input  wire logic        done_vector_ack,
  // Analog front end
  output logic             analog_power,
  output logic      [1:0]  reference_out,
  output logic      [2:0]  mux_pos,
  output logic      [2:0]  mux_neg,
  output logic             mux_diff,
  output logic             gain_20x,
  output logic             temp_select,
  output logic             sample_hold,
  output logic      [9:0]  sar_trial,
  input  wire logic        cmp_above
);
  import sar_adc_pkg::*;

  // Route word: {temp, spare, gain20, diff, neg[2:0], pos[2:0]}
  function automatic logic [9:0] route(input logic [5:0] code);
    logic [3:0] k;
    logic [2:0] p;
    logic [2:0] n;
    k = code[4:1];
    p = 3'h0;
    n = 3'h0;
    route = 10'h000;
    if (code == `TEMP_SENSOR_CODE) begin
      route = 10'h200;
    end else if (code[5:3] == 3'b000) begin
      route = {4'h0, 3'h0, code[2:0]};
    end else if (code[5] == 1'b0) begin
      unique case (k)
        4'hb: begin p = 3'h0; n = 3'h0; end
        4'hc: begin p = 3'h3; n = 3'h3; end
        4'hd: begin p = 3'h7; n = 3'h7; end
        4'he: begin p = 3'h1; n = 3'h0; end
        4'hf: begin p = 3'h7; n = 3'h6; end
        default: begin
          p = 3'(k - 4'h4);
          n = 3'(k - 4'h3);
        end
      endcase
      route = {2'b00, code[0], 1'b1, n, p};
    end
  endfunction

  // Software-visible control state
  logic       enable;
  logic       start_req;
  logic       auto_trig;
  logic       done_flag;
  logic [2:0] presc_sel;
  logic       left_adjust;
  logic [2:0] trig_sel;
  logic [5:0] chan_field;
  logic [1:0] ref_sel;
  logic       next_enable;
  logic       next_start_req;
  logic       next_auto_trig;
  logic       next_done_flag;
  logic [2:0] next_presc_sel;
  logic       next_left_adjust;
  logic [2:0] next_trig_sel;
  logic [5:0] next_chan_field;
  logic [1:0] next_ref_sel;

  // Converter state
  conv_state_type state;
  conv_kind_type  kind;
  logic [4:0]     tick_cnt;
  logic [3:0]     bit_idx;
  logic [9:0]     sar_code;
  logic [9:0]     result;
  logic           lock;
  logic           first_pending;
  logic           auto_pending;
  logic [6:0]     presc_cnt;
  logic [2:0]     trig_pipe;
  logic           trig_prev;
  logic [9:0]     chan_route;
  logic [1:0]     ref_act;
  logic [31:0]    rd_data;
  logic           rd_err;
  conv_state_type next_state;
  conv_kind_type  next_kind;
  logic [4:0]     next_tick_cnt;
  logic [3:0]     next_bit_idx;
  logic [9:0]     next_sar_code;
  logic [9:0]     next_result;
  logic           next_lock;
  logic           next_first_pending;
  logic           next_auto_pending;
  logic [6:0]     next_presc_cnt;
  logic [2:0]     next_trig_pipe;
  logic           next_trig_prev;
  logic [9:0]     next_chan_route;
  logic [1:0]     next_ref_act;
  logic [31:0]    next_rd_data;
  logic           next_rd_err;
  logic           next_sample_hold;

  // Shared decode
  logic       wr_acc;
  logic       rd_acc;
  logic       setup;
  logic       mapped;
  logic [2:0] div_exp;
  logic [6:0] presc_mask;
  logic       adc_tick;
  logic       busy;
  logic       free_run;
  logic       trig_edge;
  logic       trig_fire;
  logic       start_go;
  logic       last_tick;
  logic [4:0] conv_len;
  logic [4:0] sample_at;
  logic [9:0] final_code;

  always_comb begin
    setup  = psel && !penable;
    wr_acc = psel && penable && pwrite;
    rd_acc = psel && penable && !pwrite;
    mapped = (paddr == `CHAN_SEL_OFF) || (paddr == `CTRL_A_OFF) ||
             (paddr == `CTRL_B_OFF) || (paddr == `RES_LOW_OFF) ||
             (paddr == `RES_HIGH_OFF);
    div_exp = (presc_sel == 3'h0) ? 3'h1 : presc_sel;
    presc_mask = 7'((8'h01 << div_exp) - 8'h01);
    adc_tick = enable && ((presc_cnt & presc_mask) == presc_mask);
    busy     = (state == CONVERTING);
    free_run = auto_trig && (trig_sel == `FREE_RUN_SOURCE);
    // A flag already high after completion gives no new edge
    trig_edge = auto_trig && !free_run && trig_flags_sel() &&
                !trig_prev && !busy && !auto_pending;
    trig_fire = trig_pipe[`TRIG_SYNC_CYCLES-1];
    start_go  = !busy && adc_tick && (start_req || auto_pending);
    unique case (kind)
      FIRST: begin
        conv_len  = `FIRST_LEN;
        sample_at = `FIRST_SAMPLE;
      end
      AUTO: begin
        conv_len  = `AUTO_LEN;
        sample_at = `AUTO_SAMPLE;
      end
      default: begin
        conv_len  = `NORMAL_LEN;
        sample_at = `NORMAL_SAMPLE;
      end
    endcase
    last_tick = busy && adc_tick && (tick_cnt == conv_len - 5'd1);
    final_code = sar_code;
    if (!cmp_above) begin
      final_code[bit_idx] = 1'b0;
    end
  end

  function automatic logic trig_flags_sel();
    trig_flags_sel = trigger_flags[trig_sel];
  endfunction

  // Register file
  always_comb begin
    next_enable      = enable;
    next_start_req   = start_req;
    next_auto_trig   = auto_trig;
    next_done_flag   = done_flag;
    next_presc_sel   = presc_sel;
    next_left_adjust = left_adjust;
    next_trig_sel    = trig_sel;
    next_chan_field  = chan_field;
    next_ref_sel     = ref_sel;
    if (wr_acc && paddr == `CHAN_SEL_OFF) begin
      next_ref_sel    = pwdata[`REF_SEL_MSB:`REF_SEL_LSB];
      next_chan_field = pwdata[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
    end
    if (wr_acc && paddr == `CTRL_B_OFF) begin
      next_left_adjust = pwdata[`LEFT_ADJ_BIT];
      next_trig_sel    = pwdata[`TRIG_SEL_MSB:`TRIG_SEL_LSB];
    end
    if (done_vector_ack) begin
      next_done_flag = 1'b0;
    end
    if (wr_acc && paddr == `CTRL_A_OFF) begin
      next_enable    = pwdata[`ENABLE_BIT];
      next_auto_trig = pwdata[`AUTO_TRIG_BIT];
      next_presc_sel = pwdata[`PRESC_MSB:`PRESC_LSB];
      if (pwdata[`DONE_FLAG_BIT]) begin
        next_done_flag = 1'b0;
      end
      // Writing zero to the start bit never aborts a conversion
      if (pwdata[`START_BIT] && !busy) begin
        next_start_req = 1'b1;
      end
    end
    if (start_go) begin
      next_start_req = 1'b0;
    end
    if (!next_enable) begin
      next_start_req = 1'b0;
    end
    // Completion wins over any clear in the same cycle
    if (last_tick) begin
      next_done_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable      <= 1'(`CTRL_A_RST >> `ENABLE_BIT);
      start_req   <= 1'b0;
      auto_trig   <= 1'b0;
      done_flag   <= 1'b0;
      presc_sel   <= 3'h0;
      left_adjust <= 1'b0;
      trig_sel    <= 3'h0;
      chan_field  <= 6'h00;
      ref_sel     <= 2'h0;
    end else begin
      enable      <= next_enable;
      start_req   <= next_start_req;
      auto_trig   <= next_auto_trig;
      done_flag   <= next_done_flag;
      presc_sel   <= next_presc_sel;
      left_adjust <= next_left_adjust;
      trig_sel    <= next_trig_sel;
      chan_field  <= next_chan_field;
      ref_sel     <= next_ref_sel;
    end
  end

  // Prescaler, trigger synchroniser, sequencer, result and read data
  always_comb begin
    next_state         = state;
    next_kind          = kind;
    next_tick_cnt      = tick_cnt;
    next_bit_idx       = bit_idx;
    next_sar_code      = sar_code;
    next_result        = result;
    next_lock          = lock;
    next_first_pending = first_pending;
    next_auto_pending  = auto_pending;
    next_sample_hold   = 1'b0;
    next_chan_route    = chan_route;
    next_ref_act       = ref_act;
    next_trig_prev     = trig_flags_sel();
    next_trig_pipe     = {trig_pipe[1:0], trig_edge};
    next_presc_cnt     = 7'(presc_cnt + 7'h01);
    if (trig_fire) begin
      next_presc_cnt    = 7'h00;
      next_auto_pending = 1'b1;
    end
    if (start_go) begin
      next_state        = CONVERTING;
      next_tick_cnt     = 5'd0;
      next_auto_pending = 1'b0;
      next_first_pending = 1'b0;
      if (first_pending) begin
        next_kind = FIRST;
      end else if (auto_pending && !start_req) begin
        next_kind = AUTO;
      end else begin
        next_kind = NORMAL;
      end
    end else if (busy && adc_tick) begin
      next_tick_cnt = 5'(tick_cnt + 5'd1);
      if (tick_cnt == sample_at) begin
        next_sample_hold = 1'b1;
      end
      if (tick_cnt == conv_len - `SAR_BITS - 5'd1) begin
        next_sar_code = `SAR_MSB_CODE;
        next_bit_idx  = 4'd9;
      end else if (tick_cnt >= conv_len - `SAR_BITS) begin
        next_sar_code = final_code;
        if (bit_idx != 4'd0) begin
          next_bit_idx = 4'(bit_idx - 4'd1);
          next_sar_code[bit_idx - 4'd1] = 1'b1;
        end
      end
      if (last_tick) begin
        // A low-byte read in flight also blocks, so both bytes match
        if (!lock && !(psel && !pwrite && paddr == `RES_LOW_OFF)) begin
          next_result = final_code;
        end
        if (free_run) begin
          next_tick_cnt = 5'd0;
          next_kind     = NORMAL;
        end else begin
          next_state = IDLE;
        end
      end
    end
    // Selection is frozen during a conversion
    if (enable && (!busy || last_tick)) begin
      next_chan_route = route(chan_field);
      next_ref_act    = ref_sel;
    end
    if (rd_acc && paddr == `RES_LOW_OFF) begin
      next_lock = 1'b1;
    end
    if (rd_acc && paddr == `RES_HIGH_OFF) begin
      next_lock = 1'b0;
    end
    if (!enable) begin
      next_presc_cnt     = 7'h00;
      next_state         = IDLE;
      next_first_pending = 1'b1;
      next_auto_pending  = 1'b0;
      next_trig_pipe     = 3'h0;
    end
    next_rd_data = rd_data;
    next_rd_err  = rd_err;
    if (setup) begin
      next_rd_err  = !mapped;
      next_rd_data = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == `CHAN_SEL_OFF) begin
          next_rd_data[7:0] = {ref_sel, chan_field};
        end else if (paddr == `CTRL_A_OFF) begin
          next_rd_data[7:0] = {enable, start_req || busy, auto_trig,
                               done_flag, 1'b0, presc_sel};
        end else if (paddr == `CTRL_B_OFF) begin
          next_rd_data[7:0] = {3'h0, left_adjust, 1'b0, trig_sel};
        end else if (paddr == `RES_LOW_OFF) begin
          next_rd_data[7:0] = left_adjust ? {result[1:0], 6'h00}
                                          : result[7:0];
        end else if (paddr == `RES_HIGH_OFF) begin
          next_rd_data[7:0] = left_adjust ? result[9:2]
                                          : {6'h00, result[9:8]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= IDLE;
      kind          <= NORMAL;
      tick_cnt      <= 5'd0;
      bit_idx       <= 4'd0;
      sar_code      <= 10'h000;
      result        <= 10'h000;
      lock          <= 1'b0;
      first_pending <= 1'b1;
      auto_pending  <= 1'b0;
      presc_cnt     <= 7'h00;
      trig_pipe     <= 3'h0;
      trig_prev     <= 1'b0;
      chan_route    <= 10'h000;
      ref_act       <= 2'h0;
      rd_data       <= 32'h0000_0000;
      rd_err        <= 1'b0;
      sample_hold   <= 1'b0;
    end else begin
      state         <= next_state;
      kind          <= next_kind;
      tick_cnt      <= next_tick_cnt;
      bit_idx       <= next_bit_idx;
      sar_code      <= next_sar_code;
      result        <= next_result;
      lock          <= next_lock;
      first_pending <= next_first_pending;
      auto_pending  <= next_auto_pending;
      presc_cnt     <= next_presc_cnt;
      trig_pipe     <= next_trig_pipe;
      trig_prev     <= next_trig_prev;
      chan_route    <= next_chan_route;
      ref_act       <= next_ref_act;
      rd_data       <= next_rd_data;
      rd_err        <= next_rd_err;
      sample_hold   <= next_sample_hold;
    end
  end

  // One access cycle per transfer; answers come from setup-cycle flops
  assign pready        = penable;
  assign prdata        = rd_data;
  assign pslverr       = psel && penable && rd_err;
  assign analog_power  = enable;
  assign reference_out = ref_act;
  assign mux_pos       = chan_route[2:0];
  assign mux_neg       = chan_route[5:3];
  assign mux_diff      = chan_route[6];
  assign gain_20x      = chan_route[7];
  assign temp_select   = chan_route[9];
  assign sar_trial     = sar_code;

endmodule // sar_adc_conversion_control

/* dv/sar_adc_monitor.sv */
// Port-level checks of the converter control block.
// Assumes it is bound to the block's top module, one pclk domain.
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"

module sar_adc_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Analog side
  input wire logic        analog_power,
  input wire logic [2:0]  mux_pos,
  input wire logic [2:0]  mux_neg,
  input wire logic        mux_diff,
  input wire logic        gain_20x,
  input wire logic        temp_select,
  input wire logic        sample_hold
);
  logic access;
  logic mapped;
  logic ctl_wr;
  assign access = psel && penable;
  assign mapped = paddr inside {`CHAN_SEL_OFF, `CTRL_A_OFF, `CTRL_B_OFF,
                                `RES_LOW_OFF, `RES_HIGH_OFF};
  assign ctl_wr = access && pwrite && paddr == `CTRL_A_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_no_wait: assert property (psel |-> pready == penable)
    else $error("pready not equal to penable");
  chk_unmapped_error: assert property (access && !mapped |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  chk_mapped_clean: assert property (access && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_power_on: assert property (
    ctl_wr && pwdata[7] |-> ##[1:2] analog_power)
    else $error("enable did not power converter");
  chk_power_off: assert property (
    ctl_wr && !pwdata[7] |-> ##[1:2] !analog_power)
    else $error("disable left converter powered");
  chk_idle_no_sample: assert property (
    !analog_power && !$past(analog_power) |-> !sample_hold)
    else $error("sample while disabled");
  chk_gain_needs_diff: assert property (gain_20x |-> mux_diff)
    else $error("gain stage on single-ended input");
  chk_route_held: assert property (
    sample_hold |=> $stable({mux_pos, mux_neg, mux_diff, temp_select})[*8])
    else $error("routing changed during conversion");
  chk_sample_spacing: assert property (
    sample_hold |=> !sample_hold [*8]) else $error("samples too close");
  chk_start_samples: assert property (
    ctl_wr && pwdata[7] && pwdata[6] |-> ##[1:200] sample_hold)
    else $error("start write never sampled");
endmodule // sar_adc_monitor

bind sar_adc_conversion_control sar_adc_monitor sar_adc_monitor_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .analog_power(analog_power),
  .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_diff(mux_diff),
  .gain_20x(gain_20x), .temp_select(temp_select),
  .sample_hold(sample_hold));

/* dv/sar_adc_analog_model.sv */
// Behavioural sample-and-hold and comparator behind the block.
// Assumes one input level driven by the bench, single pclk domain.
`timescale 1ns/10ps

module sar_adc_analog_model (
  // Clock
  input wire logic       pclk,
  // Control from the block
  input wire logic       analog_power,
  input wire logic       sample_hold,
  input wire logic [9:0] sar_trial,
  // Bench side
  input wire logic [9:0] level,
  // Comparator
  output logic           cmp_above
);
  logic [9:0] held;
  logic       junk;
  initial junk = 1'b0;
  always @(posedge pclk) begin
    if (sample_hold)
      held <= level;
    // Unpowered comparator output is meaningless, so it keeps toggling
    if (!analog_power)
      junk <= ~junk;
  end
  assign cmp_above = analog_power ? (held >= sar_trial) : junk;
endmodule // sar_adc_analog_model

/* dv/test_sar_adc_conversion_control.sv */
// Self-checking bench of the converter control block.
// Assumes the block, the analog model and the checker are compiled first.
`timescale 1ns/10ps
`include "sar_adc_cfg.svh"

module test_sar_adc_conversion_control;
  logic        pclk = 0;
  logic        presetn = 0;
  logic [7:0]  paddr = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [31:0] pwdata = 0;
  logic [7:0]  trigger_flags = 0;
  logic        done_vector_ack = 0;
  logic [31:0] prdata;
  logic        pready, pslverr, analog_power, mux_diff, gain_20x;
  logic        temp_select, sample_hold, cmp_above, err;
  logic [1:0]  reference_out;
  logic [2:0]  mux_pos, mux_neg;
  logic [9:0]  sar_trial;
  logic [9:0]  level = 0;
  logic [31:0] rd;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  sar_adc_conversion_control sar_adc_conversion_control_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_flags(trigger_flags),
    .done_vector_ack(done_vector_ack), .analog_power(analog_power),
    .reference_out(reference_out), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .mux_diff(mux_diff), .gain_20x(gain_20x), .temp_select(temp_select),
    .sample_hold(sample_hold), .sar_trial(sar_trial),
    .cmp_above(cmp_above));
  sar_adc_analog_model sar_adc_analog_model_i (
    .pclk(pclk), .analog_power(analog_power), .sample_hold(sample_hold),
    .sar_trial(sar_trial), .level(level), .cmp_above(cmp_above));

  always #5 pclk = ~pclk;
  // A hang anywhere ends here instead of running forever
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("ERROR %0t: timeout", $time);
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic poll(input int b, input logic v);
    for (int i = 0; i < 200; i++) begin
      apb(`CTRL_A_OFF, 0, 0);
      if (rd[b] === v)
        return;
    end
  endtask

  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_hold !== 1'b1);
  endtask

  task automatic convert(input logic [9:0] v);
    level = v;
    apb(`CTRL_A_OFF, 1, 8'hc0);
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, rd[6]}, 1, "busy");
    poll(6, 0);
    check({31'h0, rd[6]}, 0, "idle");
  endtask

  task automatic read_result(input logic [9:0] v, input logic left);
    apb(`RES_LOW_OFF, 0, 0);
    check(rd, {24'h0, left ? {v[1:0], 6'h0} : v[7:0]}, "low");
    apb(`RES_HIGH_OFF, 0, 0);
    check(rd, {24'h0, left ? v[9:2] : {6'h0, v[9:8]}}, "high");
  endtask

  task automatic t_reset();
    apb(`CHAN_SEL_OFF, 0, 0);
    check(rd, {24'h0, `CHAN_SEL_RST}, "chan rst");
    apb(`CTRL_B_OFF, 0, 0);
    check(rd, {24'h0, `CTRL_B_RST}, "ctlb rst");
    apb(8'h14, 0, 0);
    check(rd, 0, "unmapped data");
    check({31'h0, err}, 1, "unmapped err");
  endtask

  task automatic t_routing();
    logic [7:0] code [4] = '{8'h03, 8'h49, 8'h98, 8'hdb};
    logic [7:0] exp [4] = '{8'h18, 8'hc1, 8'h9b, 8'hff};
    logic [7:0] msk [4] = '{8'hf8, 8'hff, 8'hff, 8'hff};
    apb(`CHAN_SEL_OFF, 1, {2'h0, `TEMP_SENSOR_CODE});
    @(negedge pclk);
    check({30'h0, analog_power, temp_select}, 0, "off route");
    apb(`CTRL_A_OFF, 1, 8'h80);
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, temp_select}, 1, "temp");
    for (int i = 0; i < 4; i++) begin
      apb(`CHAN_SEL_OFF, 1, code[i]);
      apb(`CTRL_A_OFF, 0, 0);
      check({22'h0, reference_out, {mux_diff, gain_20x, mux_pos, mux_neg}
        & msk[i]}, {22'h0, code[i][7:6], exp[i]}, "route");
    end
  endtask

  task automatic t_convert();
    apb(`CHAN_SEL_OFF, 1, 8'h02);
    convert(10'h2a5);
    check({31'h0, rd[4]}, 1, "done");
    read_result(10'h2a5, 0);
    apb(`CTRL_A_OFF, 1, 8'h90);
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, rd[4]}, 0, "w1c");
    apb(`CTRL_B_OFF, 1, 8'h10);
    convert(10'h15a);
    read_result(10'h15a, 1);
    apb(`CTRL_B_OFF, 1, 8'h00);
  endtask

  task automatic t_lock();
    convert(10'h0f3);
    apb(`RES_LOW_OFF, 0, 0);
    apb(`CTRL_A_OFF, 1, 8'h90);
    convert(10'h30c);
    check({31'h0, rd[4]}, 1, "done lost");
    apb(`RES_HIGH_OFF, 0, 0);
    check(rd, 0, "locked high");
    convert(10'h30c);
    read_result(10'h30c, 0);
    @(posedge pclk);
    done_vector_ack <= 1;
    @(posedge pclk);
    done_vector_ack <= 0;
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, rd[4]}, 0, "ack clear");
  endtask

  task automatic t_chan_change();
    apb(`CHAN_SEL_OFF, 1, 8'h02);
    apb(`CTRL_A_OFF, 1, 8'hc0);
    apb(`CHAN_SEL_OFF, 1, 8'h05);
    @(negedge pclk);
    check({29'h0, mux_pos}, 2, "held chan");
    poll(6, 0);
    apb(`CTRL_A_OFF, 0, 0);
    check({29'h0, mux_pos}, 5, "new chan");
  endtask

  task automatic t_free_run(input logic [2:0] sel);
    int n;
    int div;
    div = (sel == 0) ? 2 : (1 << sel);
    apb(`CTRL_A_OFF, 1, 8'h00);
    apb(`CTRL_B_OFF, 1, {5'h0, `FREE_RUN_SOURCE});
    apb(`CTRL_A_OFF, 1, {5'b11100, sel});
    gap(n);
    gap(n);
    check(32'(n), 32'(12 * div), "first gap");
    gap(n);
    check(32'(n), 32'(13 * div), "run gap");
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, rd[6]}, 1, "start stays");
    apb(`CTRL_A_OFF, 1, {5'b10000, sel});
    poll(6, 0);
  endtask

  task automatic t_auto();
    apb(`CTRL_B_OFF, 1, 8'h01);
    apb(`CTRL_A_OFF, 1, 8'ha0);
    @(posedge pclk);
    trigger_flags <= 8'h02;
    poll(6, 1);
    check({31'h0, rd[6]}, 1, "trig start");
    poll(6, 0);
    repeat (20) @(posedge pclk);
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, rd[6]}, 0, "level no start");
    apb(`CTRL_A_OFF, 1, 8'he0);
    apb(`CTRL_A_OFF, 0, 0);
    check({31'h0, rd[6]}, 1, "start in auto");
    poll(6, 0);
    trigger_flags <= 8'h00;
    @(posedge pclk);
    trigger_flags <= 8'h02;
    poll(6, 1);
    check({31'h0, rd[6]}, 1, "retrigger");
    poll(6, 0);
    trigger_flags <= 8'h00;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_routing();
    t_convert();
    t_lock();
    t_chan_change();
    t_free_run(3'd0);
    t_free_run(3'd2);
    t_auto();
    finish_test();
  end
endmodule // test_sar_adc_conversion_control
